// ==== verilog/surface_msg_host.sv ====
/*
 * Sender side of surface read, write and atomic messages: software stages per-lane words
 * over APB, this block packs header, address and body sections into 256-bit message
 * registers and streams them out with the descriptor.
 * Assumes the receiving port takes one register per MSG_VALID & MSG_READY edge.
 */
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/10ps

// Contract
// - Read messages end after the address section; nothing follows it.
// - Write data section follows the address section directly.
// - Atomic operand section follows the address section directly.
// - Sixteen-lane parameter uses two registers: lanes 0-7, then 8-15.
// - Trailing parameters may be dropped; intermediate ones never.
// - Inc/dec/pre-dec carry no operands; compare-write two; 64-bit compare-write four; others one.
// - Sixteen-lane 64-bit compare-write: lo0, hi0, lo1, hi1, two registers each.
// - Channels in red, green, blue, alpha order; skipped ones close up.
// - Sixteen-lane only untyped, so only first and second coordinates.
// - Eight-lane: one register per parameter; third and LEVEL_OF_DETAIL typed only.
// - No eight-lane typed tiled write with duplicate lane coordinates.
// - Eight-lane W-tiled write carries red only, bits 7:0 per lane; code sends the first channel chmask leaves enabled.
// - Eight-lane write: one register per enabled channel, one lane per dword.
// - Two-slot address in one register: slot 0 dwords 0-1, slot 1 dwords 4-5; typed ones also fill dwords 2-3 and 6-7.
// - Two-slot operands: dwords 0-1 and 4-5; others ignored.
// - Two-slot 64-bit compare-write fills dwords 0-3 and 4-7.
// - Two-slot write data: RGBA slot 0 dwords 0-3, slot 1 dwords 4-7.
// - Typed messages always carry the header; untyped only for pixel threads.
module surface_msg_host (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic CE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic MSG_VALID,
	input wire logic MSG_READY,
	output logic [255:0] MSG_DATA,
	output logic MSG_FIRST,
	output logic MSG_LAST,
	output surface_msg_pkg::desc_t MSG_DESC
);
	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	logic rst_q1;
	logic rst_n;

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	surface_msg_pkg::cfg_t cfg;
	surface_msg_pkg::cfg_t act;
	surface_msg_pkg::state_t state;
	logic [31:0] stage [surface_msg_pkg::STAGE_WORDS];
	logic [15:0] hdr_mask;
	logic [6:0] word_index;
	logic done;
	logic err;
	logic [4:0] addr_regs;
	logic [4:0] body_regs;
	logic [4:0] total;
	logic [7:0] chan_list;
	logic bad;
	logic [4:0] act_addr;
	logic [4:0] act_body;
	logic [7:0] act_list;
	logic [4:0] beat;
	logic [4:0] left;
	logic first;
	logic [255:0] beat_data;
	logic [63:0] pair_hit;
	logic overlap;
	logic hit_ctrl;
	logic hit_cmd;
	logic hit_status;
	logic hit_mask;
	logic hit_index;
	logic hit_data;
	logic mapped;
	logic access;
	logic wr_fire;
	logic busy;
	logic start_cmd;
	logic start_ok;
	logic emit;
	logic last_taken;

	// ------------------------------------------------------------------
	// APB slave: one wait state, write lands on the completing edge
	// ------------------------------------------------------------------
	assign access = PSEL & PENABLE & ~PREADY;
	assign wr_fire = PSEL & PENABLE & PWRITE & PREADY;

	always_comb begin
		hit_ctrl = 1'b0;
		hit_cmd = 1'b0;
		hit_status = 1'b0;
		hit_mask = 1'b0;
		hit_index = 1'b0;
		hit_data = 1'b0;
		if (PADDR == surface_msg_pkg::OFF_CTRL) begin
			hit_ctrl = 1'b1;
		end else if (PADDR == surface_msg_pkg::OFF_CMD) begin
			hit_cmd = 1'b1;
		end else if (PADDR == surface_msg_pkg::OFF_STATUS) begin
			hit_status = 1'b1;
		end else if (PADDR == surface_msg_pkg::OFF_HDR_MASK) begin
			hit_mask = 1'b1;
		end else if (PADDR == surface_msg_pkg::OFF_WORD_INDEX) begin
			hit_index = 1'b1;
		end else if (PADDR == surface_msg_pkg::OFF_WORD_DATA) begin
			hit_data = 1'b1;
		end
	end

	assign mapped = hit_ctrl | hit_cmd | hit_status | hit_mask | hit_index | hit_data;

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
		end else if (CE) begin
			PREADY <= access;
			PSLVERR <= access & ~mapped;
			if (access && !PWRITE) begin
				PRDATA <= 32'h00000000;
				if (hit_ctrl) begin
					PRDATA <= 32'(cfg);
				end else if (hit_status) begin
					PRDATA <= 32'({total, 1'b0, err, done, busy}) <<
						surface_msg_pkg::ST_BUSY_BIT;
					PRDATA[surface_msg_pkg::ST_LEN_LSB +: 5] <= total;
				end else if (hit_mask) begin
					PRDATA <= {16'h0000, hdr_mask};
				end else if (hit_index) begin
					PRDATA <= {25'h0000000, word_index};
				end else if (hit_data) begin
					PRDATA <= stage[word_index];
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Setup registers and staging store
	// ------------------------------------------------------------------
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= '0;
			hdr_mask <= 16'hFFFF;
		end else if (CE && wr_fire) begin
			if (hit_ctrl) cfg <= surface_msg_pkg::cfg_t'(PWDATA[$bits(cfg) - 1:0]);
			if (hit_mask) hdr_mask <= PWDATA[15:0];
		end
	end

	// Index steps after each data write so a whole section streams in one burst
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			word_index <= 7'h00;
		end else if (CE && wr_fire) begin
			if (hit_index) begin
				word_index <= PWDATA[6:0];
			end else if (hit_data) begin
				word_index <= 7'(word_index + 7'h01);
			end
		end
	end

	// No reset: contents are defined by software before use
	always_ff @(posedge MCLK) begin
		if (CE && wr_fire && hit_data) stage[word_index] <= PWDATA;
	end

	msg_sizer u_sizer (
		.cfg(cfg),
		.addr_regs(addr_regs),
		.body_regs(body_regs),
		.total(total),
		.chan_list(chan_list),
		.bad(bad)
	);

	// ------------------------------------------------------------------
	// Duplicate coordinate check across lane pairs
	// ------------------------------------------------------------------
	genvar gi, gj;
	generate
		for (gi = 0; gi < surface_msg_pkg::LANES; gi++) begin : g_li
			for (gj = 0; gj < surface_msg_pkg::LANES; gj++) begin : g_lj
				if (gj > gi) begin : g_pair
					always_comb begin
						pair_hit[gi * 8 + gj] = 1'b1;
						for (int p = 0; p < 4; p++) begin
							if (3'(p) < cfg.nparams &&
								stage[{1'b0, 2'(p), 1'b0, 3'(gi)}] !=
								stage[{1'b0, 2'(p), 1'b0, 3'(gj)}]) begin
								pair_hit[gi * 8 + gj] = 1'b0;
							end
						end
					end
				end else begin : g_none
					assign pair_hit[gi * 8 + gj] = 1'b0;
				end
			end
		end
	endgenerate

	// Costs a wide compare tree, but refusing here beats a silent corrupt write
	assign overlap = (|pair_hit) & cfg.typed & cfg.tiled &
		(cfg.kind == surface_msg_pkg::KIND_WRITE) &
		(cfg.mode == surface_msg_pkg::MODE_EIGHT);

	// ------------------------------------------------------------------
	// Message sequencer
	// ------------------------------------------------------------------
	assign busy = (state != surface_msg_pkg::ST_IDLE) | MSG_VALID;
	assign start_cmd = CE & wr_fire & hit_cmd & PWDATA[surface_msg_pkg::CMD_START_BIT] & ~busy;
	assign start_ok = start_cmd & ~bad & ~overlap;
	assign emit = (state != surface_msg_pkg::ST_IDLE) & (~MSG_VALID | MSG_READY);
	assign last_taken = MSG_VALID & MSG_READY & MSG_LAST;

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			state <= surface_msg_pkg::ST_IDLE;
			act <= '0;
			act_addr <= 5'h00;
			act_body <= 5'h00;
			act_list <= 8'h00;
			beat <= 5'h00;
			left <= 5'h00;
			first <= 1'b0;
			MSG_DESC <= '0;
		end else if (CE) begin
			if (start_ok) begin
				act <= cfg;
				act_addr <= addr_regs;
				act_body <= body_regs;
				act_list <= chan_list;
				beat <= 5'h00;
				left <= total;
				first <= 1'b1;
				MSG_DESC <= {total, cfg};
				state <= cfg.header ? surface_msg_pkg::ST_HEAD : surface_msg_pkg::ST_ADDR;
			end else if (emit) begin
				left <= 5'(left - 5'h01);
				first <= 1'b0;
				beat <= 5'(beat + 5'h01);
				case (state)
					surface_msg_pkg::ST_HEAD: begin
						beat <= 5'h00;
						state <= surface_msg_pkg::ST_ADDR;
					end
					surface_msg_pkg::ST_ADDR: begin
						if (beat == 5'(act_addr - 5'h01)) begin
							beat <= 5'h00;
							state <= (act_body != 5'h00) ? surface_msg_pkg::ST_BODY :
								surface_msg_pkg::ST_IDLE;
						end
					end
					surface_msg_pkg::ST_BODY: begin
						if (beat == 5'(act_body - 5'h01)) state <= surface_msg_pkg::ST_IDLE;
					end
					default: state <= surface_msg_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// Set wins over the clear that a new command write brings
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			done <= 1'b0;
			err <= 1'b0;
		end else if (CE) begin
			if (last_taken) begin
				done <= 1'b1;
			end else if (start_cmd) begin
				done <= 1'b0;
			end
			if (start_cmd) err <= bad | overlap;
		end
	end

	// ------------------------------------------------------------------
	// Register packing, one dword lane per generate step
	// ------------------------------------------------------------------
	genvar gd;
	generate
		for (gd = 0; gd < surface_msg_pkg::LANES; gd++) begin : g_dw
			localparam logic [2:0] DW = 3'(gd);
			logic [6:0] idx;
			logic keep;
			logic [1:0] sel;
			logic [2:0] unit;
			logic half;
			logic [31:0] word;

			always_comb begin
				idx = 7'h00;
				keep = 1'b0;
				unit = (act.mode == surface_msg_pkg::MODE_SIXTEEN) ? beat[3:1] : beat[2:0];
				half = (act.mode == surface_msg_pkg::MODE_SIXTEEN) ? beat[0] : 1'b0;
				sel = (act.kind == surface_msg_pkg::KIND_WRITE) ?
					act_list[2 * unit[1:0] +: 2] : unit[1:0];
				case (state)
					surface_msg_pkg::ST_ADDR: begin
						if (act.mode == surface_msg_pkg::MODE_TWO_SLOT) begin
							idx = {1'b0, DW[1:0], 3'h0, DW[2]};
							keep = (DW[1:0] < 2'h2) | act.typed;
						end else begin
							idx = {1'b0, unit[1:0], half, DW};
							keep = 1'b1;
						end
					end
					surface_msg_pkg::ST_BODY: begin
						if (act.mode == surface_msg_pkg::MODE_TWO_SLOT) begin
							idx = {1'b1, DW[1:0], 3'h0, DW[2]};
							keep = (act.kind == surface_msg_pkg::KIND_WRITE) |
								(act.opcode == surface_msg_pkg::ATOMIC_COMPARE_WRITE_64BIT) |
								(DW[1:0] < 2'h2);
						end else begin
							idx = {1'b1, sel, half, DW};
							keep = 1'b1;
						end
					end
					default: begin
						idx = 7'h00;
						keep = 1'b0;
					end
				endcase
				word = keep ? stage[idx] : 32'h00000000;
				if (state == surface_msg_pkg::ST_HEAD) begin
					word = (gd == surface_msg_pkg::HDR_MASK_DWORD) ?
						{16'h0000, hdr_mask} : 32'h00000000;
				end
				if (state == surface_msg_pkg::ST_BODY && act.tile_w) begin
					word = {24'h000000, word[surface_msg_pkg::TILE_W_BITS - 1:0]};
				end
			end

			assign beat_data[gd * 32 +: 32] = word;
		end
	endgenerate

	// ------------------------------------------------------------------
	// Stream output stage
	// ------------------------------------------------------------------
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			MSG_VALID <= 1'b0;
			MSG_DATA <= '0;
			MSG_FIRST <= 1'b0;
			MSG_LAST <= 1'b0;
		end else if (CE) begin
			if (emit) begin
				MSG_VALID <= 1'b1;
				MSG_DATA <= beat_data;
				MSG_FIRST <= first;
				MSG_LAST <= (left == 5'h01);
			end else if (MSG_READY) begin
				MSG_VALID <= 1'b0;
			end
		end
	end

endmodule : surface_msg_host

// ==== pkg/surface_msg_pkg.sv ====
/*
 * Shared constants and types for the surface message payload builder:
 * register map of the control block, message descriptor fields, atomic opcodes and
 * the layout of the word staging store.
 * Assumes a 32-bit APB register bus and a 256-bit message register stream toward the port.
 */
package surface_msg_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_CMD = 12'h004;
	localparam logic [11:0] OFF_STATUS = 12'h008;
	localparam logic [11:0] OFF_HDR_MASK = 12'h00C;
	localparam logic [11:0] OFF_WORD_INDEX = 12'h010;
	localparam logic [11:0] OFF_WORD_DATA = 12'h014;
	localparam int CMD_START_BIT = 0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_ERR_BIT = 2;
	localparam int ST_LEN_LSB = 4;

	// ------------------------------------------------------------------
	// Message encodings
	// ------------------------------------------------------------------
	localparam logic [1:0] KIND_READ = 2'h0;
	localparam logic [1:0] KIND_WRITE = 2'h1;
	localparam logic [1:0] KIND_ATOMIC = 2'h2;
	localparam logic [1:0] MODE_TWO_SLOT = 2'h0;
	localparam logic [1:0] MODE_SIXTEEN = 2'h1;
	localparam logic [1:0] MODE_EIGHT = 2'h2;
	localparam logic [3:0] ATOMIC_COMPARE_WRITE_64BIT = 4'h0;
	localparam logic [3:0] ATOMIC_INCREMENT = 4'h5;
	localparam logic [3:0] ATOMIC_DECREMENT = 4'h6;
	localparam logic [3:0] ATOMIC_SIGNED_MAX = 4'hA;
	localparam logic [3:0] ATOMIC_SIGNED_MIN = 4'hB;
	localparam logic [3:0] ATOMIC_COMPARE_WRITE = 4'hE;
	localparam logic [3:0] ATOMIC_PRE_DECREMENT = 4'hF;
	localparam logic [3:0] MASK_ALL_OFF = 4'hF;
	localparam logic [2:0] MAX_PARAMS_SIXTEEN = 3'h2;
	localparam logic [2:0] MAX_PARAMS_UNTYPED = 3'h2;
	localparam logic [2:0] MAX_PARAMS_TYPED = 3'h4;
	localparam logic [4:0] MAX_MSG_LEN = 5'h0D;

	// ------------------------------------------------------------------
	// Staging store: param p lane l at p*16+l, body part s lane l at 64+s*16+l
	// ------------------------------------------------------------------
	localparam int STAGE_WORDS = 128;
	localparam int LANES = 8;
	localparam int HDR_MASK_DWORD = 7;
	localparam int TILE_W_BITS = 8;

	typedef struct packed {
		logic [1:0] kind;
		logic [1:0] mode;
		logic typed;
		logic header;
		logic tile_w;
		logic tiled;
		logic [3:0] chmask;
		logic [3:0] opcode;
		logic [2:0] nparams;
	} cfg_t;

	typedef struct packed {
		logic [4:0] length;
		cfg_t cfg;
	} desc_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_HEAD = 4'h2,
		ST_ADDR = 4'h4,
		ST_BODY = 4'h8
	} state_t;

endpackage : surface_msg_pkg

// ==== verilog/msg_sizer.sv ====
/*
 * Message sizing: section lengths, compacted channel order and legality of a setup.
 * Purely combinational; assumes the setup is held stable by the caller.
 */
`timescale 1ns/10ps
module msg_sizer (
	input wire surface_msg_pkg::cfg_t cfg,
	output logic [4:0] addr_regs,
	output logic [4:0] body_regs,
	output logic [4:0] total,
	output logic [7:0] chan_list,
	output logic bad
);
	logic [2:0] n_ch;
	logic [2:0] units;

	always_comb begin
		n_ch = 3'h0;
		chan_list = 8'h00;
		for (int c = 0; c < 4; c++) begin
			if (!cfg.chmask[c]) begin
				chan_list[2 * n_ch +: 2] = 2'(c);
				n_ch = 3'(n_ch + 3'h1);
			end
		end
		units = 3'h0;
		if (cfg.kind == surface_msg_pkg::KIND_WRITE) begin
			units = cfg.tile_w ? 3'h1 : n_ch;
		end else if (cfg.kind == surface_msg_pkg::KIND_ATOMIC) begin
			if (cfg.opcode == surface_msg_pkg::ATOMIC_INCREMENT ||
				cfg.opcode == surface_msg_pkg::ATOMIC_DECREMENT ||
				cfg.opcode == surface_msg_pkg::ATOMIC_PRE_DECREMENT) begin
				units = 3'h0;
			end else if (cfg.opcode == surface_msg_pkg::ATOMIC_COMPARE_WRITE) begin
				units = 3'h2;
			end else if (cfg.opcode == surface_msg_pkg::ATOMIC_COMPARE_WRITE_64BIT) begin
				units = 3'h4;
			end else begin
				units = 3'h1;
			end
		end
		// Reads keep units at zero: nothing follows the address section
		if (cfg.mode == surface_msg_pkg::MODE_SIXTEEN) begin
			addr_regs = {1'b0, cfg.nparams, 1'b0};
			body_regs = {1'b0, units, 1'b0};
		end else if (cfg.mode == surface_msg_pkg::MODE_EIGHT) begin
			addr_regs = {2'h0, cfg.nparams};
			body_regs = {2'h0, units};
		end else begin
			addr_regs = 5'h01;
			body_regs = (units != 3'h0) ? 5'h01 : 5'h00;
		end
		total = 5'(addr_regs + body_regs + {4'h0, cfg.header});
		bad = 1'b0;
		if (cfg.kind == 2'h3 || cfg.mode == 2'h3) bad = 1'b1;
		if (cfg.typed && !cfg.header) bad = 1'b1;
		if (cfg.mode != surface_msg_pkg::MODE_TWO_SLOT && cfg.nparams == 3'h0) bad = 1'b1;
		if (cfg.mode == surface_msg_pkg::MODE_SIXTEEN &&
			(cfg.typed || cfg.nparams > surface_msg_pkg::MAX_PARAMS_SIXTEEN)) bad = 1'b1;
		if (cfg.mode == surface_msg_pkg::MODE_EIGHT && (cfg.nparams >
			(cfg.typed ? surface_msg_pkg::MAX_PARAMS_TYPED : surface_msg_pkg::MAX_PARAMS_UNTYPED)))
			bad = 1'b1;
		if (cfg.kind == surface_msg_pkg::KIND_WRITE && !cfg.tile_w &&
			cfg.chmask == surface_msg_pkg::MASK_ALL_OFF) bad = 1'b1;
		if (cfg.tile_w && (cfg.kind != surface_msg_pkg::KIND_WRITE ||
			cfg.mode != surface_msg_pkg::MODE_EIGHT)) bad = 1'b1;
		if (cfg.kind == surface_msg_pkg::KIND_ATOMIC && cfg.typed &&
			cfg.opcode == surface_msg_pkg::ATOMIC_COMPARE_WRITE_64BIT) bad = 1'b1;
		if (total > surface_msg_pkg::MAX_MSG_LEN) bad = 1'b1;
	end
endmodule : msg_sizer

// ==== dv/surface_msg_host_checker.sv ====
/*
 * Checker of the APB answer and the message register stream of the host.
 * Assumes aligned APB addresses and CE held high.
 */
`timescale 1ns/10ps
module surface_msg_host_checker (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic CE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic MSG_VALID,
	input wire logic MSG_READY,
	input wire logic [255:0] MSG_DATA,
	input wire logic MSG_FIRST,
	input wire logic MSG_LAST,
	input wire surface_msg_pkg::desc_t MSG_DESC
);
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	localparam logic [255:0] HI_BITS = {8{32'hFFFF_FF00}};
	localparam logic [255:0] GAP_BITS = {2{64'hFFFF_FFFF_FFFF_FFFF, 64'h0}};
	logic [4:0] taken;
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			taken <= 5'h00;
		end else if (MSG_VALID && MSG_READY) begin
			taken <= MSG_LAST ? 5'h00 : taken + 5'h01;
		end
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!NRST);
	sequence s_take;
		MSG_VALID && MSG_READY;
	endsequence
	sequence s_last_take;
		s_take ##0 MSG_LAST;
	endsequence
	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("PREADY not after one wait state");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("PREADY longer than one cycle");
	a_slverr_map: assert property (PREADY |-> (PSLVERR == (PADDR > 12'h014)))
		else $error("PSLVERR does not match address map");
	a_msg_hold: assert property (MSG_VALID && !MSG_READY |=>
		MSG_VALID && $stable(MSG_DATA) && $stable(MSG_LAST) && $stable(MSG_FIRST))
		else $error("Offered register changed before take");
	a_desc_stable: assert property (MSG_VALID && !MSG_LAST |=> $stable(MSG_DESC))
		else $error("Descriptor changed within message");
	a_len_count: assert property (s_last_take |-> taken + 5'h01 == MSG_DESC.length)
		else $error("Register count differs from length");
	a_first_mark: assert property (MSG_VALID |-> MSG_FIRST == (taken == 5'h00))
		else $error("First mark misplaced");
	a_end_release: assert property (s_last_take |=> !MSG_VALID)
		else $error("Register offered after last");
	a_header_word: assert property (MSG_VALID && MSG_FIRST && MSG_DESC.cfg.header |->
		MSG_DATA[223:0] == 224'h0 && MSG_DATA[255:240] == 16'h0)
		else $error("Header register carries more than mask");
	a_tile_red: assert property (MSG_VALID && MSG_LAST && MSG_DESC.cfg.tile_w |->
		(MSG_DATA & HI_BITS) == 256'h0)
		else $error("Tile W data above bit 7");
	a_slot_gap: assert property (MSG_VALID && MSG_FIRST && !MSG_DESC.cfg.header &&
		!MSG_DESC.cfg.typed && MSG_DESC.cfg.mode == surface_msg_pkg::MODE_TWO_SLOT |->
		(MSG_DATA & GAP_BITS) == 256'h0)
		else $error("Two-slot address gap not zero");
endmodule : surface_msg_host_checker

bind surface_msg_host surface_msg_host_checker u_chk (.MCLK(MCLK), .NRST(NRST), .CE(CE),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MSG_VALID(MSG_VALID),
	.MSG_READY(MSG_READY), .MSG_DATA(MSG_DATA), .MSG_FIRST(MSG_FIRST),
	.MSG_LAST(MSG_LAST), .MSG_DESC(MSG_DESC));

// ==== dv/msg_port_model.sv ====
/*
 * Receiving port model: takes message registers in order, stalls on request.
 * Assumes one register per edge with valid and ready both high.
 */
`timescale 1ns/10ps
module msg_port_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic valid,
	input wire logic first,
	input wire logic last,
	input wire logic [255:0] data,
	input wire surface_msg_pkg::desc_t desc,
	output logic ready
);
	logic [255:0] rx [0:15];
	logic [4:0] rx_n;
	logic [4:0] next_n;
	logic len_ok;
	logic [7:0] takes;
	assign next_n = first ? 5'h01 : rx_n + 5'h01;
	// Stalling every other cycle exercises the hold of offered registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready <= 1'b0;
		end else begin
			ready <= slow ? ~ready : 1'b1;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_n <= 5'h00;
			takes <= 8'h00;
			len_ok <= 1'b0;
		end else if (valid && ready) begin
			// Kept raw: sign is read later from opcode and surface format
			rx[next_n - 5'h01] <= data;
			rx_n <= next_n;
			takes <= takes + 8'h01;
			if (last) begin
				len_ok <= (next_n == desc.length);
			end
		end
	end
endmodule : msg_port_model

// ==== dv/surface_msg_host_tb.sv ====
/*
 * Testbench of the surface message host: APB master, port model, scenarios.
 * Assumes the checker is bound to the host.
 */
`timescale 1ns/10ps
module surface_msg_host_tb;
	logic MCLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er, slow;
	logic MSG_VALID, MSG_READY, MSG_FIRST, MSG_LAST;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic [255:0] MSG_DATA;
	surface_msg_pkg::desc_t MSG_DESC;
	logic [255:0] exp [0:15];
	int fail_count = 0;
	int n_checks = 0;
	surface_msg_host dut (.MCLK(MCLK), .NRST(NRST), .CE(1'b1), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .MSG_VALID(MSG_VALID), .MSG_READY(MSG_READY),
		.MSG_DATA(MSG_DATA), .MSG_FIRST(MSG_FIRST), .MSG_LAST(MSG_LAST), .MSG_DESC(MSG_DESC));
	msg_port_model u_port (.clk(MCLK), .rst_n(NRST), .slow(slow), .valid(MSG_VALID),
		.first(MSG_FIRST), .last(MSG_LAST), .data(MSG_DATA), .desc(MSG_DESC),
		.ready(MSG_READY));
	initial begin
		MCLK = 1'b0;
		forever #20 MCLK = ~MCLK;
	end
	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task finish_test;
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test
	task check(input logic [255:0] seen, input logic [255:0] want);
		n_checks++;
		if (seen !== want) begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h want %h", $time, seen, want);
		end
	endtask : check
	function logic [31:0] w(input int i);
		return 32'h5A5A_5A00 | i[7:0];
	endfunction : w
	function logic [255:0] lanes(input int b);
		for (int d = 0; d < 8; d++) lanes[d*32 +: 32] = w(b + d);
	endfunction : lanes
	function logic [31:0] cfg(input logic [1:0] k, input logic [1:0] m, input logic [1:0] th,
		input logic tw, input logic [3:0] cm, input logic [3:0] op, input logic [2:0] np);
		return {13'h0000, k, m, th, tw, 1'b0, cm, op, np};
	endfunction : cfg
	// Request held until PREADY is sampled high; the watchdog ends a hang
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do @(posedge MCLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge MCLK);
	endtask : apb
	task run(input logic [31:0] c, input int n);
		apb(1'b1, surface_msg_pkg::OFF_CTRL, c);
		apb(1'b1, surface_msg_pkg::OFF_CMD, 32'h0000_0001);
		rd = 32'h0;
		for (int t = 0; t < 50 && rd[1] !== 1'b1; t++) apb(1'b0, surface_msg_pkg::OFF_STATUS, 0);
		check(rd[1], 1'b1);
		check(u_port.rx_n, n[4:0]);
		check(u_port.len_ok, 1'b1);
		for (int i = 0; i < n; i++) check(u_port.rx[i], exp[i]);
	endtask : run
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task t_regs;
		apb(1'b0, surface_msg_pkg::OFF_HDR_MASK, 0);
		check(rd, 32'h0000_FFFF);
		apb(1'b0, surface_msg_pkg::OFF_STATUS, 0);
		check(rd, 32'h0000_0010);
		apb(1'b0, 12'h020, 0);
		check({er, rd}, {1'b1, 32'h0});
		apb(1'b1, surface_msg_pkg::OFF_WORD_INDEX, 0);
		for (int i = 0; i < 128; i++) apb(1'b1, surface_msg_pkg::OFF_WORD_DATA, w(i));
	endtask : t_regs
	task t_eight;
		exp[0] = lanes(0);
		run(cfg(2'h0, 2'h2, 2'b00, 1'b0, 4'h0, 4'h0, 3'h1), 1);
		slow <= 1'b1;
		exp[1] = lanes(16);
		exp[2] = lanes(64);
		exp[3] = lanes(96);
		run(cfg(2'h1, 2'h2, 2'b00, 1'b0, 4'hA, 4'h0, 3'h2), 4);
		slow <= 1'b0;
		exp[1] = lanes(64) & {8{32'h0000_00FF}};
		run(cfg(2'h1, 2'h2, 2'b00, 1'b1, 4'hE, 4'h0, 3'h1), 2);
	endtask : t_eight
	task t_sixteen;
		apb(1'b1, surface_msg_pkg::OFF_HDR_MASK, 32'h0000_3C5A);
		exp[0] = {32'h0000_3C5A, 224'h0};
		for (int k = 0; k < 4; k++) exp[1 + k] = lanes(8 * k);
		for (int k = 0; k < 8; k++) exp[5 + k] = lanes(64 + 8 * k);
		run(cfg(2'h2, 2'h1, 2'b01, 1'b0, 4'h0, 4'h0, 3'h2), 13);
	endtask : t_sixteen
	task t_two_slot;
		exp[0] = {64'h0, w(17), w(1), 64'h0, w(16), w(0)};
		for (int d = 0; d < 4; d++) exp[1][d*32 +: 32] = w(64 + 16 * d);
		for (int d = 0; d < 4; d++) exp[1][d*32 + 128 +: 32] = w(65 + 16 * d);
		run(cfg(2'h2, 2'h0, 2'b00, 1'b0, 4'h0, 4'h0, 3'h2), 2);
		run(cfg(2'h1, 2'h0, 2'b00, 1'b0, 4'h0, 4'h0, 3'h2), 2);
		exp[1] = {64'h0, w(81), w(65), 64'h0, w(80), w(64)};
		run(cfg(2'h2, 2'h0, 2'b00, 1'b0, 4'h0, 4'hE, 3'h2), 2);
	endtask : t_two_slot
	task t_lengths;
		logic [3:0] ops [7] = '{4'h5, 4'h6, 4'hF, 4'hA, 4'hB, 4'hE, 4'h0};
		logic [4:0] lens [7] = '{5'h01, 5'h01, 5'h01, 5'h02, 5'h02, 5'h03, 5'h05};
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, surface_msg_pkg::OFF_CTRL, cfg(2'h2, 2'h2, 2'b00, 1'b0, 4'h0, ops[i], 3'h1));
			apb(1'b0, surface_msg_pkg::OFF_STATUS, 0);
			check(rd[8:4], lens[i]);
		end
	endtask : t_lengths
	task t_refused;
		logic [7:0] n0;
		logic [31:0] bad [3] = '{cfg(2'h0, 2'h1, 2'b11, 1'b0, 4'h0, 4'h0, 3'h1),
			cfg(2'h0, 2'h2, 2'b00, 1'b0, 4'h0, 4'h0, 3'h3),
			cfg(2'h1, 2'h2, 2'b11, 1'b0, 4'hE, 4'h0, 3'h1) | 32'h0000_0800};
		// Lanes 0 and 1 share a first coordinate for the tiled typed write
		apb(1'b1, surface_msg_pkg::OFF_WORD_INDEX, 32'h0000_0001);
		apb(1'b1, surface_msg_pkg::OFF_WORD_DATA, w(0));
		for (int i = 0; i < 3; i++) begin
			n0 = u_port.takes;
			apb(1'b1, surface_msg_pkg::OFF_CTRL, bad[i]);
			apb(1'b1, surface_msg_pkg::OFF_CMD, 32'h0000_0001);
			repeat (4) @(posedge MCLK);
			apb(1'b0, surface_msg_pkg::OFF_STATUS, 0);
			check(rd[2], 1'b1);
			check(u_port.takes, n0);
		end
	endtask : t_refused
	initial begin
		#2400000;
		fail_count++;
		finish_test;
	end
	initial begin
		NRST = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h000;
		PWDATA = 32'h0;
		slow = 1'b0;
		repeat (20) @(posedge MCLK);
		NRST <= 1'b1;
		repeat (3) @(posedge MCLK);
		t_regs;
		t_eight;
		t_sixteen;
		t_two_slot;
		t_lengths;
		t_refused;
		finish_test;
	end
endmodule : surface_msg_host_tb
